// file: src/arc_pkg.sv
// package for the analog front-end routing control register bank
// assumes byte addressing on the bus, one 32-bit word per register index
package arc_pkg;

    // register indices; byte address is four times the index
    localparam logic [5:0] IDX_LOD_EN    = 6'h07;
    localparam logic [5:0] IDX_LOD_CUR   = 6'h08;
    localparam logic [5:0] IDX_AC_DIV    = 6'h09;
    localparam logic [5:0] IDX_CM_EN     = 6'h0A;
    localparam logic [5:0] IDX_CM_CTL    = 6'h0B;
    localparam logic [5:0] IDX_RL_CTL    = 6'h0C;
    localparam logic [5:0] IDX_WCT1      = 6'h0D;
    localparam logic [5:0] IDX_WCT2      = 6'h0E;
    localparam logic [5:0] IDX_WCT3      = 6'h0F;
    localparam logic [5:0] IDX_LIMB_REF  = 6'h10;
    localparam logic [5:0] IDX_REF_CTL   = 6'h11;
    localparam logic [5:0] IDX_STATUS    = 6'h1E;

    // field positions
    localparam int POS_AC_PRESCALE  = 7;
    localparam int POS_CM_BW        = 2;
    localparam int POS_RL_BW        = 6;
    localparam int POS_RL_CAP       = 4;
    localparam int POS_RL_OFF       = 3;
    localparam int POS_AUG_ROUTE    = 1;
    localparam int POS_CT_ROUTE     = 0;
    localparam int POS_COMMON_OFF   = 1;
    localparam int POS_INTERNAL_OFF = 0;

    // current step in nA per code
    localparam logic [3:0] LOD_STEP_NA  = 4'h8;
    // extra division factor when prescale is selected
    localparam logic [4:0] AC_PRESCALE  = 5'h10;

    typedef struct packed {
        logic       input1_lead_off_enable;
        logic [7:0] lead_off_current_code;
        logic       ac_test_prescale_select;
        logic [6:0] ac_test_divider_ratio;
        logic [5:0] common_mode_input_enables;
        logic       common_mode_bandwidth;
        logic [1:0] common_mode_cap_drive;
        logic       right_leg_bandwidth;
        logic [1:0] right_leg_cap_drive;
        logic       right_leg_amp_off;
        logic [2:0] right_leg_output_mux;
        logic [2:0] wct_buffer_one_input;
        logic [2:0] wct_buffer_two_input;
        logic [2:0] wct_buffer_three_input;
        logic       augmented_ref_internal_route;
        logic       central_terminal_internal_route;
        logic       common_ref_off;
        logic       internal_ref_off;
    } arc_cfg_s;

    // all documented fields reset to zero
    localparam arc_cfg_s CFG_RESET = '0;

    typedef enum logic [1:0] {
        BUS_IDLE = 2'b01,
        BUS_ACK  = 2'b10
    } arc_bus_e;

endpackage : arc_pkg

// file: src/arc_regs.sv
// register bank and steering outputs for the analog front-end routing controls
// assumes an Avalon-MM master on SYS_CLK and a power-down level from the device core
//
// Notes on behaviour
// R1 - bit 0 enables lead-off on input 1
// R2 - 8-bit current code, 8 nA per step
// R3 - bit 7 selects divide-by-one or sixteen
// R4 - bits 6:0 divide clock for AC test
// R5 - six common-mode input enables, MSB is input 6
// R6 - bit 2 selects common-mode bandwidth
// R7 - two-bit common-mode cap drive select
// R8 - right-leg bandwidth bit and cap drive field
// R9 - bit 3 powers right-leg amplifier down
// R10 - right-leg mux: 000 off, 001-110 inputs
// R11 - three buffer selectors: 000 off, 001-110 inputs
// R12 - bit 1 routes augmented refs to inputs 4-6
// R13 - bit 0 routes central terminal to input 6
// R14 - software never sets both routing bits together
// R15 - bit 1 shuts common and right-leg reference
// R16 - bit 0 shuts internal 2.4 V reference
// R17 - power-down forces both references off
// R18 - software should also shut common reference
// R19 - reserved bits read zero, writes ignored
`timescale 1ns/1ns
`default_nettype none

module arc_regs (
    // clock and reset
    input  wire logic        SYS_CLK,
    input  wire logic        RST,
    // Avalon-MM slave
    input  wire logic [7:0]  ADDRESS,
    input  wire logic        READ,
    input  wire logic        WRITE,
    input  wire logic [31:0] WRITEDATA,
    input  wire logic [3:0]  BYTEENABLE,
    output var  logic [31:0] READDATA,
    output var  logic        WAITREQUEST,
    // device mode
    input  wire logic        POWER_DOWN,
    // lead-off controls
    output var  logic        INPUT1_LEAD_OFF_ENABLE,
    output var  logic [7:0]  LEAD_OFF_CURRENT_CODE,
    output var  logic [10:0] LEAD_OFF_CURRENT_NA,
    output var  logic        AC_TEST_CLOCK,
    // common-mode detector
    output var  logic [5:0]  COMMON_MODE_INPUT_ENABLES,
    output var  logic        COMMON_MODE_BANDWIDTH,
    output var  logic [1:0]  COMMON_MODE_CAP_DRIVE,
    // right-leg amplifier
    output var  logic        RIGHT_LEG_BANDWIDTH,
    output var  logic [1:0]  RIGHT_LEG_CAP_DRIVE,
    output var  logic        RIGHT_LEG_AMP_OFF,
    output var  logic [5:0]  RIGHT_LEG_CONNECT,
    // central-terminal buffers, one-hot per electrode input
    output var  logic [5:0]  WCT_BUFFER_ONE_CONNECT,
    output var  logic [5:0]  WCT_BUFFER_TWO_CONNECT,
    output var  logic [5:0]  WCT_BUFFER_THREE_CONNECT,
    // internal routing to electrode inputs 4 to 6
    output var  logic [2:0]  AUGMENTED_REF_TO_INPUT_4_6,
    output var  logic        CENTRAL_TERMINAL_TO_INPUT_6,
    // reference shutdowns
    output var  logic        COMMON_REF_OFF,
    output var  logic        INTERNAL_REF_OFF
);

    // selector code to one-hot electrode connection; 111 connects nothing
    // one-hot form keeps a selector from closing two switches at once
    function automatic logic [5:0] sel_to_onehot(input logic [2:0] sel);
        logic [5:0] hot;
        hot = 6'h00;
        unique case (sel)
            3'h1: hot = 6'h01;
            3'h2: hot = 6'h02;
            3'h3: hot = 6'h04;
            3'h4: hot = 6'h08;
            3'h5: hot = 6'h10;
            3'h6: hot = 6'h20;
            default: hot = 6'h00;
        endcase
        return hot;
    endfunction : sel_to_onehot

    // register byte as software sees it; unused bits stay zero
    function automatic logic [7:0] reg_byte(input arc_pkg::arc_cfg_s c, input logic [5:0] idx,
                                            input logic [7:0] stat);
        logic [7:0] b;
        b = 8'h00;
        unique case (idx)
            arc_pkg::IDX_LOD_EN:   b[0]   = c.input1_lead_off_enable;
            arc_pkg::IDX_LOD_CUR:  b      = c.lead_off_current_code;
            arc_pkg::IDX_AC_DIV:   b      = {c.ac_test_prescale_select, c.ac_test_divider_ratio};
            arc_pkg::IDX_CM_EN:    b[5:0] = c.common_mode_input_enables;
            arc_pkg::IDX_CM_CTL:   b[2:0] = {c.common_mode_bandwidth, c.common_mode_cap_drive};
            arc_pkg::IDX_RL_CTL:   b[6:0] = {c.right_leg_bandwidth, c.right_leg_cap_drive,
                                             c.right_leg_amp_off, c.right_leg_output_mux};
            arc_pkg::IDX_WCT1:     b[2:0] = c.wct_buffer_one_input;
            arc_pkg::IDX_WCT2:     b[2:0] = c.wct_buffer_two_input;
            arc_pkg::IDX_WCT3:     b[2:0] = c.wct_buffer_three_input;
            arc_pkg::IDX_LIMB_REF: b[1:0] = {c.augmented_ref_internal_route,
                                             c.central_terminal_internal_route};
            arc_pkg::IDX_REF_CTL:  b[1:0] = {c.common_ref_off, c.internal_ref_off};
            arc_pkg::IDX_STATUS:   b      = stat;
            default:               b      = 8'h00;
        endcase
        return b;
    endfunction : reg_byte

    arc_pkg::arc_cfg_s cfg_q;
    arc_pkg::arc_bus_e bus_q;

    logic [5:0]  idx;
    logic        aligned;
    logic        wr_commit;
    logic [7:0]  wbyte;
    logic [7:0]  status;

    logic [31:0] readdata_q;
    logic        waitrequest_q;

    logic [3:0]  pre_cnt_q;
    logic [6:0]  div_cnt_q;
    logic        ac_clk_q;
    logic        pre_tick;
    logic [3:0]  pre_limit;
    logic        ac_stop;

    logic        lod_en_q;
    logic [7:0]  lod_cur_q;
    logic [10:0] lod_na_q;
    logic [5:0]  cm_en_q;
    logic        cm_bw_q;
    logic [1:0]  cm_cap_q;
    logic        rl_bw_q;
    logic [1:0]  rl_cap_q;
    logic        rl_off_q;
    logic [5:0]  rl_conn_q;
    logic [5:0]  wct1_q;
    logic [5:0]  wct2_q;
    logic [5:0]  wct3_q;
    logic [2:0]  aug_q;
    logic        ct6_q;
    logic        common_off_q;
    logic        internal_off_q;

    // address decode: only word-aligned addresses reach a register
    assign idx       = ADDRESS[7:2];
    assign aligned   = (ADDRESS[1:0] == 2'b00);
    // lane 0 carries the register byte; upper lanes are ignored
    assign wbyte     = WRITEDATA[7:0];
    assign wr_commit = (bus_q == arc_pkg::BUS_ACK) && WRITE && BYTEENABLE[0] && aligned;

    // read-only view of effective state
    assign status = {3'h0, POWER_DOWN, ac_clk_q,
                     cfg_q.augmented_ref_internal_route & cfg_q.central_terminal_internal_route,
                     common_off_q, internal_off_q};

    // bus handshake: one wait cycle, then a single ready cycle
    // request lines are levels; one still high after the answer is taken again
    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            bus_q         <= arc_pkg::BUS_IDLE;
            waitrequest_q <= 1'b1;
        end else begin
            unique case (bus_q)
                arc_pkg::BUS_IDLE: begin
                    if (READ || WRITE) begin
                        bus_q         <= arc_pkg::BUS_ACK;
                        waitrequest_q <= 1'b0;
                    end
                end
                arc_pkg::BUS_ACK: begin
                    bus_q         <= arc_pkg::BUS_IDLE;
                    waitrequest_q <= 1'b1;
                end
            endcase
        end
    end

    // read data captured in the wait cycle and held until the next read
    // misaligned reads answer zero rather than an error
    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            readdata_q <= 32'h0000_0000;
        end else if ((bus_q == arc_pkg::BUS_IDLE) && READ) begin
            readdata_q <= aligned ? {24'h00_0000, reg_byte(cfg_q, idx, status)} : 32'h0000_0000; // R19
        end
    end

    // register writes; only implemented bits are stored
    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            cfg_q <= arc_pkg::CFG_RESET;
        end else if (wr_commit) begin
            unique case (idx)
                arc_pkg::IDX_LOD_EN: begin
                    cfg_q.input1_lead_off_enable <= wbyte[0]; // R1
                end
                arc_pkg::IDX_LOD_CUR: begin
                    cfg_q.lead_off_current_code <= wbyte; // R2
                end
                arc_pkg::IDX_AC_DIV: begin
                    cfg_q.ac_test_prescale_select <= wbyte[arc_pkg::POS_AC_PRESCALE]; // R3
                    cfg_q.ac_test_divider_ratio   <= wbyte[6:0]; // R4
                end
                arc_pkg::IDX_CM_EN: begin
                    cfg_q.common_mode_input_enables <= wbyte[5:0]; // R5
                end
                arc_pkg::IDX_CM_CTL: begin
                    cfg_q.common_mode_bandwidth <= wbyte[arc_pkg::POS_CM_BW]; // R6
                    cfg_q.common_mode_cap_drive <= wbyte[1:0]; // R7
                end
                arc_pkg::IDX_RL_CTL: begin
                    cfg_q.right_leg_bandwidth  <= wbyte[arc_pkg::POS_RL_BW]; // R8
                    cfg_q.right_leg_cap_drive  <= wbyte[arc_pkg::POS_RL_CAP +: 2]; // R8
                    cfg_q.right_leg_amp_off    <= wbyte[arc_pkg::POS_RL_OFF]; // R9
                    cfg_q.right_leg_output_mux <= wbyte[2:0]; // R10
                end
                arc_pkg::IDX_WCT1: begin
                    cfg_q.wct_buffer_one_input <= wbyte[2:0]; // R11
                end
                arc_pkg::IDX_WCT2: begin
                    cfg_q.wct_buffer_two_input <= wbyte[2:0]; // R11
                end
                arc_pkg::IDX_WCT3: begin
                    cfg_q.wct_buffer_three_input <= wbyte[2:0]; // R11
                end
                arc_pkg::IDX_LIMB_REF: begin
                    cfg_q.augmented_ref_internal_route    <= wbyte[arc_pkg::POS_AUG_ROUTE]; // R12
                    cfg_q.central_terminal_internal_route <= wbyte[arc_pkg::POS_CT_ROUTE]; // R13
                end
                arc_pkg::IDX_REF_CTL: begin
                    cfg_q.common_ref_off   <= wbyte[arc_pkg::POS_COMMON_OFF]; // R15
                    cfg_q.internal_ref_off <= wbyte[arc_pkg::POS_INTERNAL_OFF]; // R16
                end
                default: begin
                    cfg_q <= cfg_q; // R19
                end
            endcase
        end
    end

    // AC test clock: prescale by 1 or 16, then half period of ratio ticks
    assign pre_limit = cfg_q.ac_test_prescale_select ? 4'(arc_pkg::AC_PRESCALE - 5'h01) : 4'h0; // R3
    assign pre_tick  = (pre_cnt_q >= pre_limit);
    // ratio zero parks both counters so a new ratio starts from a clean phase
    assign ac_stop   = (cfg_q.ac_test_divider_ratio == 7'h00);

    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            pre_cnt_q <= 4'h0;
        end else if (ac_stop || pre_tick) begin
            pre_cnt_q <= 4'h0;
        end else begin
            pre_cnt_q <= pre_cnt_q + 4'h1;
        end
    end

    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            div_cnt_q <= 7'h00;
            ac_clk_q  <= 1'b0;
        end else if (ac_stop) begin
            // ratio zero stops the test clock low
            div_cnt_q <= 7'h00;
            ac_clk_q  <= 1'b0;
        end else if (pre_tick) begin
            if (div_cnt_q >= cfg_q.ac_test_divider_ratio - 7'h01) begin // R4
                div_cnt_q <= 7'h00;
                ac_clk_q  <= ~ac_clk_q;
            end else begin
                div_cnt_q <= div_cnt_q + 7'h01;
            end
        end
    end

    // lead-off outputs
    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            lod_en_q  <= 1'b0;
            lod_cur_q <= 8'h00;
            lod_na_q  <= 11'h000;
        end else begin
            lod_en_q  <= cfg_q.input1_lead_off_enable; // R1
            lod_cur_q <= cfg_q.lead_off_current_code; // R2
            lod_na_q  <= 11'(cfg_q.lead_off_current_code) * 11'(arc_pkg::LOD_STEP_NA); // R2
        end
    end

    // common-mode detector outputs
    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            cm_en_q  <= 6'h00;
            cm_bw_q  <= 1'b0;
            cm_cap_q <= 2'h0;
        end else begin
            cm_en_q  <= cfg_q.common_mode_input_enables; // R5
            cm_bw_q  <= cfg_q.common_mode_bandwidth; // R6
            cm_cap_q <= cfg_q.common_mode_cap_drive; // R7
        end
    end

    // right-leg amplifier outputs
    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            rl_bw_q   <= 1'b0;
            rl_cap_q  <= 2'h0;
            rl_off_q  <= 1'b0;
            rl_conn_q <= 6'h00;
        end else begin
            rl_bw_q   <= cfg_q.right_leg_bandwidth; // R8
            rl_cap_q  <= cfg_q.right_leg_cap_drive; // R8
            rl_off_q  <= cfg_q.right_leg_amp_off; // R9
            rl_conn_q <= sel_to_onehot(cfg_q.right_leg_output_mux); // R10
        end
    end

    // buffer selectors and internal routing
    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            wct1_q <= 6'h00;
            wct2_q <= 6'h00;
            wct3_q <= 6'h00;
            aug_q  <= 3'h0;
            ct6_q  <= 1'b0;
        end else begin
            wct1_q <= sel_to_onehot(cfg_q.wct_buffer_one_input); // R11
            wct2_q <= sel_to_onehot(cfg_q.wct_buffer_two_input); // R11
            wct3_q <= sel_to_onehot(cfg_q.wct_buffer_three_input); // R11
            aug_q  <= {3{cfg_q.augmented_ref_internal_route}}; // R12
            // both set is a software fault; passed through, flagged in status
            ct6_q  <= cfg_q.central_terminal_internal_route; // R13 R14
        end
    end

    // reference shutdowns, forced off in power-down
    // power-down overrides without touching what software reads back
    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            common_off_q   <= 1'b0;
            internal_off_q <= 1'b0;
        end else begin
            common_off_q   <= cfg_q.common_ref_off | POWER_DOWN; // R15 R17
            internal_off_q <= cfg_q.internal_ref_off | POWER_DOWN; // R16 R17
        end
    end

    // port drive
    assign READDATA                    = readdata_q;
    assign WAITREQUEST                 = waitrequest_q;
    assign INPUT1_LEAD_OFF_ENABLE      = lod_en_q;
    assign LEAD_OFF_CURRENT_CODE       = lod_cur_q;
    assign LEAD_OFF_CURRENT_NA         = lod_na_q;
    assign AC_TEST_CLOCK               = ac_clk_q;
    assign COMMON_MODE_INPUT_ENABLES   = cm_en_q;
    assign COMMON_MODE_BANDWIDTH       = cm_bw_q;
    assign COMMON_MODE_CAP_DRIVE       = cm_cap_q;
    assign RIGHT_LEG_BANDWIDTH         = rl_bw_q;
    assign RIGHT_LEG_CAP_DRIVE         = rl_cap_q;
    assign RIGHT_LEG_AMP_OFF           = rl_off_q;
    assign RIGHT_LEG_CONNECT           = rl_conn_q;
    assign WCT_BUFFER_ONE_CONNECT      = wct1_q;
    assign WCT_BUFFER_TWO_CONNECT      = wct2_q;
    assign WCT_BUFFER_THREE_CONNECT    = wct3_q;
    assign AUGMENTED_REF_TO_INPUT_4_6  = aug_q;
    assign CENTRAL_TERMINAL_TO_INPUT_6 = ct6_q;
    assign COMMON_REF_OFF              = common_off_q;
    assign INTERNAL_REF_OFF            = internal_off_q;

endmodule : arc_regs

`default_nettype wire

// file: bench/arc_regs_sva.sv
// checker for the routing control register bank
// sees only arc_regs ports; bound to every arc_regs instance below
`timescale 1ns/1ns
`default_nettype none
module arc_regs_sva (
    // clock and reset
    input wire logic        SYS_CLK,
    input wire logic        RST,
    // register bus
    input wire logic        READ,
    input wire logic        WRITE,
    input wire logic [31:0] READDATA,
    input wire logic        WAITREQUEST,
    // controls
    input wire logic        POWER_DOWN,
    input wire logic [7:0]  LEAD_OFF_CURRENT_CODE,
    input wire logic [10:0] LEAD_OFF_CURRENT_NA,
    input wire logic [5:0]  RIGHT_LEG_CONNECT,
    input wire logic [5:0]  WCT_BUFFER_ONE_CONNECT,
    input wire logic [5:0]  WCT_BUFFER_TWO_CONNECT,
    input wire logic [5:0]  WCT_BUFFER_THREE_CONNECT,
    input wire logic [2:0]  AUGMENTED_REF_TO_INPUT_4_6,
    input wire logic        COMMON_REF_OFF,
    input wire logic        INTERNAL_REF_OFF
);
    default clocking cb @(posedge SYS_CLK);
    endclocking
    default disable iff (RST);
    sequence s_taken;
        (READ || WRITE) && WAITREQUEST;
    endsequence
    sequence s_ack;
        !WAITREQUEST ##1 WAITREQUEST;
    endsequence
    a_request_answered: assert property (s_taken |=> s_ack)
        else $error("request not answered after one wait cycle");
    a_wait_single: assert property (!WAITREQUEST |=> WAITREQUEST)
        else $error("waitrequest low longer than one cycle");
    a_idle_holds_wait: assert property (!READ && !WRITE && WAITREQUEST |=> WAITREQUEST)
        else $error("answer without a request");
    a_read_upper_zero: assert property (READ && !WAITREQUEST |-> READDATA[31:8] == 24'h0)
        else $error("read data upper bits not zero");
    a_current_scale: assert property (LEAD_OFF_CURRENT_NA == {LEAD_OFF_CURRENT_CODE, 3'b000})
        else $error("current in nA is not eight times the code");
    a_power_down_refs: assert property (POWER_DOWN |=> COMMON_REF_OFF && INTERNAL_REF_OFF)
        else $error("power-down did not shut both references");
    a_right_leg_onehot: assert property ($onehot0(RIGHT_LEG_CONNECT))
        else $error("right-leg output on more than one input");
    a_buffer_onehot: assert property ($onehot0(WCT_BUFFER_ONE_CONNECT) && $onehot0(WCT_BUFFER_TWO_CONNECT)
                                      && $onehot0(WCT_BUFFER_THREE_CONNECT))
        else $error("buffer connected to more than one input");
    a_aug_ref_group: assert property (AUGMENTED_REF_TO_INPUT_4_6 inside {3'b000, 3'b111})
        else $error("augmented reference routes not switched together");
endmodule : arc_regs_sva
bind arc_regs arc_regs_sva u_sva (.SYS_CLK, .RST, .READ, .WRITE, .READDATA, .WAITREQUEST, .POWER_DOWN,
    .LEAD_OFF_CURRENT_CODE, .LEAD_OFF_CURRENT_NA, .RIGHT_LEG_CONNECT, .WCT_BUFFER_ONE_CONNECT,
    .WCT_BUFFER_TWO_CONNECT, .WCT_BUFFER_THREE_CONNECT, .AUGMENTED_REF_TO_INPUT_4_6, .COMMON_REF_OFF,
    .INTERNAL_REF_OFF);
`default_nettype wire

// file: bench/afe_routing_control_regs_bench.sv
// self-checking bench for arc_regs: bus tasks, read scoreboard, output checks
// assumes arc_pkg compiled first and the checker bound from its own file
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, ex, got) begin tests_run++; if ((got) !== (ex)) begin errors++; \
    $display("BAD %s expected %0h seen %0h", nm, ex, got); end end
module afe_routing_control_regs_bench;
    logic        sys_clk, rst, read, write, wait_req, pd, in1_en, ac_clk, cm_bw, rl_bw, rl_off, ct, cref, iref;
    logic [7:0]  address, cur_code;
    logic [31:0] wdata, rdata, exp_v, rv;
    logic [3:0]  be;
    logic [10:0] cur_na;
    logic [5:0]  cm_en, rl_con, w1, w2, w3;
    logic [1:0]  cm_cap, rl_cap;
    logic [2:0]  aug;
    logic [7:0]  mdl [0:63];
    logic [31:0] exp_q [$];
    logic        prv;
    int          errors, tests_run, seed, i, c;

    arc_regs u_dut (.SYS_CLK(sys_clk), .RST(rst), .ADDRESS(address), .READ(read), .WRITE(write),
        .WRITEDATA(wdata), .BYTEENABLE(be), .READDATA(rdata), .WAITREQUEST(wait_req), .POWER_DOWN(pd),
        .INPUT1_LEAD_OFF_ENABLE(in1_en), .LEAD_OFF_CURRENT_CODE(cur_code), .LEAD_OFF_CURRENT_NA(cur_na),
        .AC_TEST_CLOCK(ac_clk), .COMMON_MODE_INPUT_ENABLES(cm_en), .COMMON_MODE_BANDWIDTH(cm_bw),
        .COMMON_MODE_CAP_DRIVE(cm_cap), .RIGHT_LEG_BANDWIDTH(rl_bw), .RIGHT_LEG_CAP_DRIVE(rl_cap),
        .RIGHT_LEG_AMP_OFF(rl_off), .RIGHT_LEG_CONNECT(rl_con), .WCT_BUFFER_ONE_CONNECT(w1),
        .WCT_BUFFER_TWO_CONNECT(w2), .WCT_BUFFER_THREE_CONNECT(w3), .AUGMENTED_REF_TO_INPUT_4_6(aug),
        .CENTRAL_TERMINAL_TO_INPUT_6(ct), .COMMON_REF_OFF(cref), .INTERNAL_REF_OFF(iref));

    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end

    function automatic logic [7:0] mask_of(input logic [5:0] ix);
        case (ix)
            arc_pkg::IDX_LOD_EN: return 8'h01;
            arc_pkg::IDX_LOD_CUR, arc_pkg::IDX_AC_DIV: return 8'hFF;
            arc_pkg::IDX_CM_EN: return 8'h3F;
            arc_pkg::IDX_RL_CTL: return 8'h7F;
            arc_pkg::IDX_CM_CTL, arc_pkg::IDX_WCT1, arc_pkg::IDX_WCT2, arc_pkg::IDX_WCT3: return 8'h07;
            arc_pkg::IDX_LIMB_REF, arc_pkg::IDX_REF_CTL: return 8'h03;
            default: return 8'h00;
        endcase
    endfunction : mask_of

    function automatic logic [5:0] dec(input logic [2:0] code);
        return (code >= 3'h1 && code <= 3'h6) ? 6'h01 << (code - 3'h1) : 6'h00;
    endfunction : dec

    task automatic end_sim();
        $display("checks %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : end_sim

    task automatic bus(input logic wr, input logic [7:0] ad, input logic [31:0] wd, input logic [3:0] b);
        int n;
        @(posedge sys_clk);
        read <= !wr;
        write <= wr;
        address <= ad;
        wdata <= wd;
        be <= b;
        if (!wr) exp_q.push_back({24'h0, mdl[ad[7:2]] & {8{ad[1:0] == 2'b00}}});
        else if (b[0] && ad[1:0] == 2'b00) mdl[ad[7:2]] = wd[7:0] & mask_of(ad[7:2]);
        for (n = 0; n < 20; n++) begin
            @(posedge sys_clk);
            if (wait_req === 1'b0) break;
        end
        read <= 1'b0;
        write <= 1'b0;
        if (n == 20) begin
            errors++;
            $display("BAD waitrequest expected 0 seen 1");
            end_sim();
        end
    endtask : bus

    task automatic chk_out();
        repeat (2) @(posedge sys_clk);
        #1;
        `CHK("in1_en", mdl[7][0], in1_en)
        `CHK("cur_code", mdl[8], cur_code)
        `CHK("cur_na", {mdl[8], 3'b000}, cur_na)
        `CHK("cm_en", mdl[10][5:0], cm_en)
        `CHK("cm_bw", mdl[11][2], cm_bw)
        `CHK("cm_cap", mdl[11][1:0], cm_cap)
        `CHK("rl_bw", mdl[12][6], rl_bw)
        `CHK("rl_cap", mdl[12][5:4], rl_cap)
        `CHK("rl_off", mdl[12][3], rl_off)
        `CHK("rl_con", dec(mdl[12][2:0]), rl_con)
        `CHK("w1", dec(mdl[13][2:0]), w1)
        `CHK("w2", dec(mdl[14][2:0]), w2)
        `CHK("w3", dec(mdl[15][2:0]), w3)
        `CHK("aug", {3{mdl[16][1]}}, aug)
        `CHK("ct", mdl[16][0], ct)
        `CHK("cref", mdl[17][1] | pd, cref)
        `CHK("iref", mdl[17][0] | pd, iref)
    endtask : chk_out

    // period measured between second and third rise to skip reconfiguration
    task automatic ac_check(input logic [7:0] v, input int per);
        int n, r, first;
        r = 0;
        first = 0;
        bus(1'b1, {arc_pkg::IDX_AC_DIV, 2'b00}, {24'h0, v}, 4'hF);
        for (n = 0; n < 400 && r < 3; n++) begin
            @(posedge sys_clk);
            if (ac_clk === 1'b1 && prv === 1'b0) begin
                if (r == 1) first = n;
                r++;
            end
            prv = ac_clk;
        end
        if (per == 0) `CHK("ac idle rises", 0, r)
        else `CHK("ac period", per, (r == 3) ? n - 1 - first : -1)
    endtask : ac_check

    // read scoreboard: oldest note against each answered read
    always @(posedge sys_clk) begin
        if (read === 1'b1 && wait_req === 1'b0) begin
            `CHK("read note", 1'b1, exp_q.size() != 0)
            if (exp_q.size() != 0) begin
                exp_v = exp_q.pop_front();
                `CHK("readdata", exp_v, rdata)
            end
        end
    end

    initial begin
        repeat (100000) @(posedge sys_clk);
        errors++;
        $display("BAD run length expected below 100000 seen 100000");
        end_sim();
    end

    initial begin
        seed = 32'h6BF4;
        {rst, read, write, pd, prv} = 5'b10000;
        address = 8'h00;
        wdata = 32'h0;
        be = 4'h0;
        foreach (mdl[k]) mdl[k] = 8'h00;
        repeat (10) @(posedge sys_clk);
        rst <= 1'b0;
        for (i = 6; i < 32; i++) bus(1'b0, i[5:0] << 2, 32'h0, 4'hF);
        bus(1'b0, 8'h21, 32'h0, 4'hF);
        chk_out();
        $display("test reset defaults done");
        for (c = 0; c < 8; c++) begin
            for (i = 12; i < 16; i++) bus(1'b1, i[5:0] << 2, {$random(seed)} & 32'hFFFFFFF8 | c, 4'hF);
            chk_out();
        end
        $display("test selector codes done");
        for (c = 0; c < 60; c++) begin
            i = 7 + {$random(seed)} % 12;
            rv = $random(seed);
            if (i == 16 && rv[1:0] == 2'b11) rv[1] = 1'b0;
            if (i == 17 && rv[0]) rv[1] = 1'b1;
            bus(1'b1, (i[5:0] << 2) | ({$random(seed)} % 8 == 0), rv, {$random(seed)} % 4 == 0 ? 4'hE : 4'hF);
            bus(1'b0, i[5:0] << 2, 32'h0, 4'hF);
            chk_out();
        end
        bus(1'b1, 8'h80, 32'hFF, 4'hF);
        bus(1'b0, 8'h80, 32'h0, 4'hF);
        $display("test random writes and refusals done");
        bus(1'b1, {arc_pkg::IDX_REF_CTL, 2'b00}, 32'h0, 4'hF);
        pd <= 1'b1;
        chk_out();
        @(posedge sys_clk);
        pd <= 1'b0;
        chk_out();
        $display("test power-down done");
        ac_check(8'h03, 6);
        ac_check(8'h83, 96);
        ac_check(8'h00, 0);
        pd <= 1'b1;
        mdl[30] = 8'h13;
        bus(1'b0, {arc_pkg::IDX_STATUS, 2'b00}, 32'h0, 4'hF);
        pd <= 1'b0;
        mdl[30] = 8'h00;
        $display("test ac divider done");
        @(posedge sys_clk);
        rst <= 1'b1;
        repeat (2) @(posedge sys_clk);
        rst <= 1'b0;
        foreach (mdl[k]) mdl[k] = 8'h00;
        for (i = 7; i < 18; i++) bus(1'b0, i[5:0] << 2, 32'h0, 4'hF);
        chk_out();
        $display("test second reset done");
        for (i = 0; i < 20 && exp_q.size() > 0; i++) @(posedge sys_clk);
        end_sim();
    end
endmodule : afe_routing_control_regs_bench
`default_nettype wire
